// ===== shared/sbba_pkg.sv
// constants and types for the serial bus byte access engine
package sbba_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_BYTE_DATA   = 8'hB0;
  localparam logic [7:0] OFF_BYTE_INDEX  = 8'hB1;
  localparam logic [7:0] OFF_TARGET_ADDR = 8'hB2;
  localparam logic [7:0] OFF_CTRL_STAT   = 8'hB3;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // ==========================================================
  // control/status fields
  localparam int BIT_SHORT_SEL = 7;
  localparam int BIT_BUSY      = 5;
  localparam int BIT_REQ_ERR   = 1;
  localparam int BIT_DIRECTION = 0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ==========================================================
  // types
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_START   = 6'h02,
    ST_SEND    = 6'h04,
    ST_RECV    = 6'h08,
    ST_RESTART = 6'h10,
    ST_STOP    = 6'h20
  } sbba_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbba_reg_req_type;

endpackage

// ===== tb/sbba_target_model.sv
// behavioural serial bus target memory for the byte access bench
`timescale 1ns/1ps
module sbba_target_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_stretch,
  output logic      o_scl_oe_n,
  output logic      o_sda_oe_n
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] idx;
  logic       sel;
  logic       rd;
  int         n;
  int         nb;
  initial
  begin
    o_scl_oe_n = 1'b1;
    o_sda_oe_n = 1'b1;
    idx = 8'h00;
    sel = 1'b0;
    rd = 1'b0;
    n = 0;
    nb = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = ~i[7:0];
  end
  // ==========
  // start and stop
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      n = 0;
      nb = 0;
    end
  always @(posedge i_sda)
    if (i_scl === 1'b1)
      sel = 1'b0;
  // ==========
  // bit and byte handling
  always @(posedge i_scl)
  begin
    if (n < 8)
      sh = {sh[6:0], i_sda};
    if (n == 8 && rd && i_sda)
      sel = 1'b0;
    n++;
  end
  always @(negedge i_scl)
  begin
    if (n == 8 && (nb == 0 || !rd))
    begin
      if (nb == 0)
      begin
        sel = (sh[7:1] == DEV_ADDR);
        rd = sh[0];
      end
      else if (sel && nb == 1)
        idx = sh;
      else if (sel)
        mem[idx] = sh;
      if (sel && nb > 1)
        idx++;
      o_sda_oe_n = !sel;
      nb++;
    end
    else if (n == 8)
      o_sda_oe_n = 1'b1;
    else if (n == 9)
    begin
      n = 0;
      tx = mem[idx];
      o_sda_oe_n = !(sel && rd) || tx[7];
      if (sel && rd)
        idx++;
    end
    else if (sel && rd && n >= 1 && n < 8)
      o_sda_oe_n = tx[7-n];
  end
  // ==========
  // slow target holds the clock low
  always @(negedge i_scl)
    if (i_stretch)
    begin
      o_scl_oe_n = 1'b0;
      #200;
      o_scl_oe_n = 1'b1;
    end
endmodule // sbba_target_model

// ===== tb/serial_bus_byte_access_tb.sv
// self-checking bench for the serial bus byte access engine
`timescale 1ns/1ps
module serial_bus_byte_access_tb
  import sbba_pkg::*;
;
  logic             clock = 1'b0;
  logic             rst_n = 1'b0;
  logic             stretch = 1'b0;
  sbba_reg_req_type req = '0;
  logic [7:0]       rdata;
  logic             d_scl_out;
  logic             d_sda_out;
  logic             d_scl_oe_n;
  logic             d_sda_oe_n;
  logic             t_scl_oe_n;
  logic             t_sda_oe_n;
  int               fails = 0;
  int               n_tests = 0;
  logic [7:0]       rd_idx [3] = '{8'h12, 8'h7E, 8'hFF};
  logic [7:0]       rd_exp [3] = '{8'h3C, 8'h81, 8'h00};
  wire logic        scl = d_scl_oe_n & t_scl_oe_n;
  wire logic        sda = d_sda_oe_n & t_sda_oe_n;
  always #5 clock = ~clock;
  sbba_top #(.QUARTER(4)) dut (
    .i_clock     (clock),
    .i_rst_n     (rst_n),
    .i_reg       (req),
    .o_reg_rdata (rdata),
    .i_scl_in    (scl),
    .o_scl_out   (d_scl_out),
    .o_scl_oe_n  (d_scl_oe_n),
    .i_sda_in    (sda),
    .o_sda_out   (d_sda_out),
    .o_sda_oe_n  (d_sda_oe_n)
  );
  sbba_target_model tgt (
    .i_scl      (scl),
    .i_sda      (sda),
    .i_stretch  (stretch),
    .o_scl_oe_n (t_scl_oe_n),
    .o_sda_oe_n (t_sda_oe_n)
  );
  // ==========
  // access tasks
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
    @(posedge clock);
    #1;
    d = rdata;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    n_tests++;
    if (seen !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic expect_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_rd(a, v);
    check(nm, v, e);
  endtask
  task automatic wait_idle;
    logic [7:0] v;
    for (int i = 0; i < 600; i++)
    begin
      reg_rd(OFF_CTRL_STAT, v);
      if (v[BIT_BUSY] === 1'b0)
        return;
    end
    check("busy wait", 8'h01, 8'h00);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // watchdog
  initial
  begin
    #400000;
    fails++;
    tally_and_finish();
  end
  // ==========
  // scenarios
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    expect_rd("data reset", OFF_BYTE_DATA, RESET_BYTE);
    expect_rd("index reset", OFF_BYTE_INDEX, RESET_BYTE);
    expect_rd("target reset", OFF_TARGET_ADDR, RESET_BYTE);
    expect_rd("status reset", OFF_CTRL_STAT, RESET_BYTE);
    expect_rd("unmapped", 8'hB4, 8'h00);
    check("pins released", {6'h00, d_scl_oe_n, d_sda_oe_n}, 8'h03);
    check("drive levels", {6'h00, d_scl_out, d_sda_out}, 8'h00);
    stretch <= 1'b1;
    reg_wr(OFF_BYTE_DATA, 8'h3C);
    reg_wr(OFF_BYTE_INDEX, 8'h12);
    reg_wr(OFF_TARGET_ADDR, 8'hA0);
    expect_rd("busy set", OFF_CTRL_STAT, 8'h20);
    reg_wr(OFF_BYTE_DATA, 8'hFF);
    wait_idle();
    stretch <= 1'b0;
    check("written byte", tgt.mem[8'h12], 8'h3C);
    expect_rd("data kept", OFF_BYTE_DATA, 8'h3C);
    expect_rd("target kept", OFF_TARGET_ADDR, 8'hA0);
    expect_rd("no error", OFF_CTRL_STAT, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(OFF_BYTE_INDEX, rd_idx[k]);
      reg_wr(OFF_TARGET_ADDR, 8'hA1);
      wait_idle();
      expect_rd("read data", OFF_BYTE_DATA, rd_exp[k]);
    end
    reg_wr(OFF_BYTE_DATA, 8'h77);
    reg_wr(OFF_BYTE_INDEX, 8'h12);
    reg_wr(OFF_TARGET_ADDR, 8'hC0);
    wait_idle();
    check("foreign target", tgt.mem[8'h12], 8'h3C);
    expect_rd("error set", OFF_CTRL_STAT, 8'h02);
    reg_wr(OFF_CTRL_STAT, 8'h02);
    expect_rd("error clear", OFF_CTRL_STAT, 8'h00);
    reg_wr(OFF_CTRL_STAT, 8'h80);
    expect_rd("short select", OFF_CTRL_STAT, 8'h80);
    reg_wr(OFF_BYTE_DATA, 8'h99);
    reg_wr(OFF_TARGET_ADDR, 8'hA0);
    wait_idle();
    check("send byte", tgt.idx, 8'h99);
    reg_wr(OFF_TARGET_ADDR, 8'hA1);
    wait_idle();
    expect_rd("receive byte", OFF_BYTE_DATA, 8'h66);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    expect_rd("data cleared", OFF_BYTE_DATA, 8'h00);
    expect_rd("index cleared", OFF_BYTE_INDEX, 8'h00);
    expect_rd("target cleared", OFF_TARGET_ADDR, 8'h00);
    expect_rd("status cleared", OFF_CTRL_STAT, 8'h00);
    tally_and_finish();
  end
endmodule // serial_bus_byte_access_tb

// ===== verilog/sbba_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sbba_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // ==========================================================
  // per bit chain
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        s1        <= 1'b1;
        s2        <= 1'b1;
        s3        <= 1'b1;
        o_sync[g] <= 1'b1;
      end
      else
      begin
        s1 <= i_async[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
          o_sync[g] <= s3;
      end
    end
  end
endmodule // sbba_sync

// ===== verilog/sbba_top.sv
// serial bus byte access engine: registers and bus sequencer
`timescale 1ns/1ps
// Operation
// - for a read software loads index then address with direction 1, polls busy, data is valid.
// - an 8-bit data field supplies the written byte and receives the read byte.
// - an 8-bit index field is sent as the byte address in reads and writes.
// - target address bits 7 to 1 are presented on the bus for each transaction.
// - target address bit 0 is the direction bit, 0 write and 1 read.
// - data, index and target address are cleared only by the global reset.
// - writing the target address launches a transaction and sets busy until done.
// - a missing acknowledge sets the error flag, cleared by writing 1.
// - with short protocol select set, send-byte and receive-byte forms omit the index.
module sbba_top
  import sbba_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire sbba_reg_req_type i_reg,
  output logic      [7:0]       o_reg_rdata,
  input  wire logic             i_scl_in,
  output logic                  o_scl_out,
  output logic                  o_scl_oe_n,
  input  wire logic             i_sda_in,
  output logic                  o_sda_out,
  output logic                  o_sda_oe_n
);
  if (QUARTER < 2 || QUARTER > 65536)
  begin : g_bad_quarter
    $error("sbba_top: QUARTER must lie between 2 and 65536");
  end

  sbba_state_type state;
  sbba_state_type next_state;
  logic [7:0]  byte_data;
  logic [7:0]  byte_index;
  logic [7:0]  target_addr;
  logic        short_sel;
  logic        busy;
  logic        req_err;
  logic [15:0] qcnt;
  logic [1:0]  phase;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit;
  logic [1:0]  stage;
  logic [1:0]  next_stage;
  logic        after_rs;
  logic        next_after_rs;
  logic [7:0]  tx_shift;
  logic [7:0]  next_tx;
  logic [7:0]  rx_shift;
  logic        sampled;
  logic        scl_low;
  logic        sda_low;
  logic        scl_s;
  logic        sda_s;
  logic        tick;
  logic        end_sym;
  logic        launch;
  logic        err_set;
  logic        recv_load;
  logic        is_read;
  logic        wr_ok;

  // ==========================================================
  // pin synchronisers
  sbba_sync #(.WIDTH(2)) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_scl_in, i_sda_in}),
    .o_sync  ({scl_s, sda_s})
  );

  assign o_scl_out  = 1'b0;
  assign o_sda_out  = 1'b0;
  assign o_scl_oe_n = ~scl_low;
  assign o_sda_oe_n = ~sda_low;

  assign is_read   = target_addr[BIT_DIRECTION];
  assign wr_ok     = i_reg.wr && !busy;
  assign launch    = wr_ok && (i_reg.addr == OFF_TARGET_ADDR);
  assign tick      = busy && (qcnt == '0) && !(phase == 2'd1 && !scl_s);
  assign end_sym   = tick && (phase == 2'd3);
  assign err_set   = end_sym && (state == ST_SEND) && (bit_cnt == ACK_BIT) && sampled;
  assign recv_load = tick && (phase == 2'd1) && (state == ST_RECV) && (bit_cnt == 4'h7);

  // ==========================================================
  // sequencer next values
  always_comb
  begin
    next_state    = state;
    next_bit      = bit_cnt;
    next_stage    = stage;
    next_tx       = tx_shift;
    next_after_rs = after_rs;
    unique case (state)
      ST_IDLE:
        next_state = ST_IDLE;
      ST_START, ST_RESTART:
      begin
        next_state = ST_SEND;
        next_bit   = '0;
        next_stage = '0;
        next_after_rs = (state == ST_RESTART);
        // direction bit, write before the index
        next_tx = {target_addr[7:1],
                   is_read && (short_sel || state == ST_RESTART)};
      end
      ST_SEND:
      begin
        if (bit_cnt != ACK_BIT)
        begin
          next_bit = bit_cnt + 4'h1;
          next_tx  = {tx_shift[6:0], 1'b0};
        end
        else if (sampled)
          next_state = ST_STOP;
        else
        begin
          next_bit   = '0;
          next_stage = stage + 2'd1;
          if (is_read && (short_sel || after_rs))
            next_state = ST_RECV;
          else if (!short_sel && stage == 2'd0)
            next_tx = byte_index;
          else if (is_read)
            next_state = ST_RESTART;
          else if (stage == (short_sel ? 2'd0 : 2'd1))
            next_tx = byte_data;
          else
            next_state = ST_STOP;
        end
      end
      ST_RECV:
      begin
        next_bit = bit_cnt + 4'h1;
        if (bit_cnt == ACK_BIT)
          next_state = ST_STOP;
      end
      ST_STOP:
        next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // state and counters
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state    <= ST_IDLE;
      bit_cnt  <= '0;
      stage    <= '0;
      after_rs <= 1'b0;
      tx_shift <= RESET_BYTE;
      phase    <= '0;
      qcnt     <= '0;
    end
    else
    begin
      if (launch)
      begin
        state <= ST_START;
        phase <= '0;
        qcnt  <= 16'(QUARTER - 1);
      end
      else if (tick)
      begin
        phase <= phase + 2'd1;
        qcnt  <= 16'(QUARTER - 1);
        if (end_sym)
        begin
          state    <= next_state;
          bit_cnt  <= next_bit;
          stage    <= next_stage;
          after_rs <= next_after_rs;
          tx_shift <= next_tx;
        end
      end
      else if (qcnt != '0)
        qcnt <= qcnt - 16'h1;
    end
  end

  // ==========================================================
  // bus pin drive
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (launch)
      sda_low <= 1'b0;
    else if (end_sym)
    begin
      unique case (next_state)
        ST_SEND:
        begin
          scl_low <= 1'b1;
          sda_low <= (next_bit != ACK_BIT) && !next_tx[7];
        end
        ST_RECV:
        begin
          scl_low <= 1'b1;
          sda_low <= 1'b0;
        end
        ST_STOP:
        begin
          scl_low <= 1'b1;
          sda_low <= 1'b1;
        end
        ST_RESTART:
          sda_low <= 1'b0;
        default:
          sda_low <= 1'b0;
      endcase
    end
    else if (tick)
    begin
      if (phase == 2'd0)
        scl_low <= 1'b0;
      else if (phase == 2'd1 && (state == ST_START || state == ST_RESTART))
        sda_low <= 1'b1;
      else if (phase == 2'd1 && state == ST_STOP)
        sda_low <= 1'b0;
      else if (phase == 2'd2 && state != ST_STOP)
        scl_low <= 1'b1;
    end
  end

  // ==========================================================
  // bit sampling
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sampled  <= 1'b0;
      rx_shift <= RESET_BYTE;
    end
    else if (tick && phase == 2'd1)
    begin
      sampled <= sda_s;
      if (state == ST_RECV && bit_cnt != ACK_BIT)
        rx_shift <= {rx_shift[6:0], sda_s};
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      byte_data   <= RESET_BYTE;
      byte_index  <= RESET_BYTE;
      target_addr <= RESET_BYTE;
      short_sel   <= 1'b0;
    end
    else
    begin
      if (recv_load)
        byte_data <= {rx_shift[6:0], sda_s};
      else if (wr_ok && i_reg.addr == OFF_BYTE_DATA)
        byte_data <= i_reg.wdata;
      if (wr_ok && i_reg.addr == OFF_BYTE_INDEX)
        byte_index <= i_reg.wdata;
      if (launch)
        target_addr <= i_reg.wdata;
      if (i_reg.wr && i_reg.addr == OFF_CTRL_STAT)
        short_sel <= i_reg.wdata[BIT_SHORT_SEL];
    end
  end

  // busy and error flags
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy    <= 1'b0;
      req_err <= 1'b0;
    end
    else
    begin
      if (launch)
        busy <= 1'b1;
      else if (end_sym && state == ST_STOP)
        busy <= 1'b0;
      if (err_set)
        req_err <= 1'b1;
      else if (i_reg.wr && i_reg.addr == OFF_CTRL_STAT && i_reg.wdata[BIT_REQ_ERR])
        req_err <= 1'b0;
    end
  end

  // read port
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= RESET_BYTE;
    else if (i_reg.rd)
    begin
      unique case (i_reg.addr)
        OFF_BYTE_DATA:   o_reg_rdata <= byte_data;
        OFF_BYTE_INDEX:  o_reg_rdata <= byte_index;
        OFF_TARGET_ADDR: o_reg_rdata <= target_addr;
        OFF_CTRL_STAT:
          o_reg_rdata <= (8'(short_sel) << BIT_SHORT_SEL) | (8'(busy) << BIT_BUSY)
                       | (8'(req_err) << BIT_REQ_ERR);
        default:         o_reg_rdata <= RESET_BYTE;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  launch_sets_busy_a: assert property (launch |=> busy && state == ST_START)
    else $error("launch did not set busy");
  read_data_ready_a: assert property (
    $fell(busy) && is_read && !req_err |-> byte_data == rx_shift)
    else $error("read data not in place as busy fell");
  stop_clears_busy_a: assert property (
    end_sym && state == ST_STOP |=> !busy && state == ST_IDLE)
    else $error("busy not cleared after stop");
  addr_on_bus_a: assert property (
    state == ST_SEND && bit_cnt == 4'h0 && stage == 2'd0
    && $changed(state) |-> tx_shift[7:1] == target_addr[7:1])
    else $error("target address not sent");
  dir_bit_sent_a: assert property (
    $past(state) == ST_RESTART && state == ST_SEND
    |-> tx_shift[0] == 1'b1 && is_read)
    else $error("direction bit wrong after restart");
  index_sent_a: assert property (
    end_sym && state == ST_SEND && bit_cnt == ACK_BIT && !sampled && stage == 2'd0
    && !short_sel && !after_rs |=> tx_shift == byte_index)
    else $error("index byte not sent");
  nack_error_a: assert property (err_set |=> req_err && state == ST_STOP)
    else $error("nack did not flag and stop");
  regs_hold_a: assert property (
    !i_reg.wr && !recv_load |=> $stable(byte_data)
    && $stable(byte_index) && $stable(target_addr))
    else $error("register changed without cause");
  short_no_rs_a: assert property (
    short_sel && busy && $stable(short_sel) |-> state != ST_RESTART)
    else $error("repeated start in short form");
  read_frame_a: assert property (state == ST_RESTART |-> is_read && stage == 2'd2)
    else $error("restart outside long read");
  data_written_a: assert property (
    state == ST_STOP && $changed(state) && !is_read
    && !req_err |-> $past(tx_shift) == 8'h00 && stage != 2'd0)
    else $error("write ended early");

  write_done_c: cover property (busy && !is_read ##1 !busy);
  read_done_c: cover property (recv_load ##[1:1000] !busy);
  nack_seen_c: cover property (err_set);
  stretch_c: cover property (busy && phase == 2'd1 && qcnt == '0 && !scl_s);
endmodule // sbba_top
